// ### src/imsmx_seq.sv
// Sampling and multiplexer sequencer with APB registers and sample FIFO.
`timescale 1ns/1ps
module imsmx_seq #(
  parameter int SW = imsmx_pkg::SAMPLE_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reference_sample_clock,
  input wire logic data_sample_clock,
  input wire logic converter_clock,
  input wire logic line_start,
  input wire logic clamp_enable,
  input wire logic [SW-1:0] conv_result,
  output logic [1:0] mux_select,
  output logic reference_hold,
  output logic data_hold,
  output logic convert_start,
  output logic clamp_bias_on,
  output logic [4:0] gain_code_red,
  output logic [4:0] gain_code_green,
  output logic [4:0] gain_code_blue,
  output logic [7:0] offset_code_red,
  output logic [7:0] offset_code_green,
  output logic [7:0] offset_code_blue,
  output logic fifo_overrun
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: five pins, two flip-flops each.
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] prev_reg;
  wire [4:0] pins = {line_start, clamp_enable, converter_clock,
                     data_sample_clock, reference_sample_clock};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      prev_reg <= 5'h00;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  wire ref_s = sync2_reg[0];
  wire ref_fall = prev_reg[0] && !sync2_reg[0];
  wire dat_fall = prev_reg[1] && !sync2_reg[1];
  wire cck_rise = !prev_reg[2] && sync2_reg[2];
  wire clamp_s = sync2_reg[3];
  wire start_s = sync2_reg[4];
  wire start_fall = prev_reg[4] && !sync2_reg[4];

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [6:0] config_reg;
  logic [7:0] offset_reg [3];
  logic [4:0] gain_reg [3];
  wire setup_ok = psel && !penable;
  wire wr_en = psel && penable && pwrite && pready;
  wire rd_en = psel && penable && !pwrite && pready;
  wire single_sample = config_reg[imsmx_pkg::SINGLE_SAMPLE_POS];
  wire one_channel = config_reg[imsmx_pkg::COUNT_POS];
  wire [1:0] chan_sel = config_reg[imsmx_pkg::SELECT_POS +: 2];
  wire order_bgr = config_reg[imsmx_pkg::ORDER_POS];
  wire [1:0] mode = {one_channel, single_sample};
  wire addr_ofs = (paddr == imsmx_pkg::OFS_RED_OFF) || (paddr == imsmx_pkg::OFS_GRN_OFF)
                  || (paddr == imsmx_pkg::OFS_BLU_OFF);
  wire addr_gain = (paddr == imsmx_pkg::GAIN_RED_OFF) || (paddr == imsmx_pkg::GAIN_GRN_OFF)
                   || (paddr == imsmx_pkg::GAIN_BLU_OFF);
  wire addr_ok = addr_ofs || addr_gain || (paddr == imsmx_pkg::CONFIG_OFF)
                 || (paddr == imsmx_pkg::STATUS_OFF) || (paddr == imsmx_pkg::DATA_OFF);
  wire [1:0] ofs_idx = 2'((paddr - imsmx_pkg::OFS_RED_OFF) >> 2);
  wire [1:0] gain_idx = 2'((paddr - imsmx_pkg::GAIN_RED_OFF) >> 2);

  // Configuration and per-channel trims; written on the APB access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= imsmx_pkg::CONFIG_RST;
      for (int i = 0; i < 3; i++) begin
        offset_reg[i] <= imsmx_pkg::OFFSET_RST;
        gain_reg[i] <= imsmx_pkg::GAIN_RST;
      end
    end else if (wr_en) begin
      if (paddr == imsmx_pkg::CONFIG_OFF) config_reg <= pwdata[6:0];
      if (addr_ofs) offset_reg[ofs_idx] <= pwdata[7:0];
      if (addr_gain) gain_reg[gain_idx] <= pwdata[4:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Multiplexer sequencing.
  wire [1:0] first_ch = order_bgr ? imsmx_pkg::CH_BLUE : imsmx_pkg::CH_RED;
  wire [1:0] last_ch = order_bgr ? imsmx_pkg::CH_RED : imsmx_pkg::CH_BLUE;
  wire [1:0] step_ch = (mux_select == last_ch) ? first_ch :
                       (order_bgr ? mux_select - 2'h1 : mux_select + 2'h1);
  wire [1:0] fixed_ch = (chan_sel == 2'h3) ? imsmx_pkg::CH_RED : chan_sel;
  logic [1:0] mux_next;
  always_comb begin
    mux_next = mux_select;
    if (one_channel) mux_next = fixed_ch;
    else if (start_fall) mux_next = first_ch;
    else if (cck_rise) mux_next = step_ch;
  end

  // Sample strobes and conversion start.
  logic line_active_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_select <= 2'h0;
      reference_hold <= 1'b0;
      data_hold <= 1'b0;
      convert_start <= 1'b0;
      clamp_bias_on <= 1'b0;
      line_active_reg <= 1'b0;
    end else begin
      mux_select <= mux_next;
      reference_hold <= ref_fall;
      data_hold <= dat_fall && !single_sample;
      if (start_s) line_active_reg <= 1'b1;
      convert_start <= cck_rise && (start_s || line_active_reg);
      clamp_bias_on <= clamp_s && !single_sample;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trim outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_code_red <= 5'h00;
      gain_code_green <= 5'h00;
      gain_code_blue <= 5'h00;
      offset_code_red <= 8'h00;
      offset_code_green <= 8'h00;
      offset_code_blue <= 8'h00;
    end else begin
      gain_code_red <= gain_reg[0];
      gain_code_green <= gain_reg[1];
      gain_code_blue <= gain_reg[2];
      offset_code_red <= offset_reg[0];
      offset_code_green <= offset_reg[1];
      offset_code_blue <= offset_reg[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result FIFO: each conversion's result is pushed with the channel it came from.
  wire f_in_ready;
  wire [SW+1:0] f_out;
  wire f_out_valid;
  wire f_pop = rd_en && (paddr == imsmx_pkg::DATA_OFF);
  imsmx_fifo #(.WIDTH(SW + 2), .DEPTH(imsmx_pkg::FIFO_DEPTH)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_data({mux_select, conv_result}),
    .in_valid(convert_start),
    .in_ready(f_in_ready),
    .out_data(f_out),
    .out_valid(f_out_valid),
    .out_ready(f_pop)
  );

  // Overrun is sticky; a status write with bit 0 set clears it, a new loss wins.
  wire ovr_set = convert_start && !f_in_ready;
  wire ovr_clr = wr_en && (paddr == imsmx_pkg::STATUS_OFF) && pwdata[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fifo_overrun <= 1'b0;
    else if (ovr_set) fifo_overrun <= 1'b1;
    else if (ovr_clr) fifo_overrun <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read mux and answer; no wait states, so pready rises in the access cycle.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == imsmx_pkg::CONFIG_OFF) rd_mux = {25'h0, config_reg};
    else if (addr_ofs) rd_mux = {24'h0, offset_reg[ofs_idx]};
    else if (addr_gain) rd_mux = {27'h0, gain_reg[gain_idx]};
    else if (paddr == imsmx_pkg::STATUS_OFF)
      rd_mux = {22'h0, mux_select, mode, line_active_reg, clamp_bias_on,
                ref_s, f_in_ready, f_out_valid, fifo_overrun};
    else if (paddr == imsmx_pkg::DATA_OFF)
      rd_mux = {15'h0, f_out_valid, 2'h0, f_out};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ok;
      prdata <= setup_ok ? rd_mux : 32'h0000_0000;
      pslverr <= setup_ok && !addr_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence fall_seen_s;
    prev_reg[1] && !sync2_reg[1];
  endsequence
  mux_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    one_channel && chan_sel != 2'h3 |=> mux_select == $past(chan_sel))
    else $error("mux left the selected channel");
  mux_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    !one_channel && start_fall |=> mux_select == $past(first_ch))
    else $error("mux not at first channel after line start");
  mux_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    !one_channel && !start_fall && cck_rise && mux_select != 2'h3
    |=> mux_select != $past(mux_select))
    else $error("mux did not advance");
  mux_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    mux_select != 2'h3)
    else $error("mux on illegal channel");
  data_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    single_sample |=> !data_hold)
    else $error("data sampled in single mode");
  data_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    fall_seen_s ##0 !single_sample |=> data_hold)
    else $error("data sample missed");
  ref_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    ref_fall |=> reference_hold ##1 (!reference_hold || $past(ref_fall)))
    else $error("reference sample missed");
  clamp_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    clamp_bias_on |-> $past(clamp_s) && !$past(single_sample))
    else $error("clamp bias outside double mode");
  conv_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    convert_start |-> $past(cck_rise))
    else $error("conversion without converter clock rise");
endmodule : imsmx_seq

// ### src/imsmx_pkg.sv
// Package of constants for the image sampler mux sequencer.
package imsmx_pkg;
  // APB register byte offsets.
  localparam logic [7:0] CONFIG_OFF = 8'h00;
  localparam logic [7:0] OFS_RED_OFF = 8'h04;
  localparam logic [7:0] OFS_GRN_OFF = 8'h08;
  localparam logic [7:0] OFS_BLU_OFF = 8'h0C;
  localparam logic [7:0] GAIN_RED_OFF = 8'h10;
  localparam logic [7:0] GAIN_GRN_OFF = 8'h14;
  localparam logic [7:0] GAIN_BLU_OFF = 8'h18;
  localparam logic [7:0] STATUS_OFF = 8'h1C;
  localparam logic [7:0] DATA_OFF = 8'h20;
  // Configuration field positions.
  localparam int SINGLE_SAMPLE_POS = 0;
  localparam int COUNT_POS = 3;
  localparam int SELECT_POS = 4;
  localparam int ORDER_POS = 6;
  localparam int CONFIG_WIDTH = 7;
  // Reset values.
  localparam logic [6:0] CONFIG_RST = 7'h00;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [4:0] GAIN_RST = 5'h00;
  localparam int OFFSET_WIDTH = 8;
  localparam int GAIN_WIDTH = 5;
  localparam int SAMPLE_WIDTH = 12;
  localparam int FIFO_DEPTH = 16;
  // Channel codes.
  typedef enum logic [1:0] {CH_RED, CH_GREEN, CH_BLUE, CH_NONE} imsmx_chan_type;
  typedef enum logic [1:0] {
    MODE_TRI_DOUBLE, MODE_TRI_SINGLE, MODE_ONE_DOUBLE, MODE_ONE_SINGLE
  } imsmx_mode_type;
endpackage : imsmx_pkg

// ### src/imsmx_fifo.sv
// Synchronous FIFO holding converted samples with their channel tag.
`timescale 1ns/1ps
module imsmx_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic out_valid_reg;
  wire push;
  wire pop;
  wire load;

  // Accept while fewer than DEPTH words are held, the output register included.
  // Counting only the storage would let one word more in than the buffer is sized for.
  assign in_ready = ((count_reg + (AW+1)'(out_valid_reg)) != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (count_reg != '0) && (!out_valid_reg || out_ready);
  assign pop = load;
  assign out_data = out_data_reg;
  assign out_valid = out_valid_reg;

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, occupancy and the registered read port.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_data_reg <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      if (load) begin
        out_data_reg <= mem_reg[rd_ptr_reg];
        out_valid_reg <= 1'b1;
      end else if (out_ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule : imsmx_fifo

// ### testbench/imsmx_timing_gen.sv
// Behavioural timing generator that drives the sensor sample and converter clocks.
`timescale 1ns/1ps
module imsmx_timing_gen (
  input wire logic pclk,
  input wire logic run,
  input wire logic one_ch,
  input wire logic single,
  input wire logic line_go,
  input wire logic clamp_req,
  output logic reference_sample_clock,
  output logic data_sample_clock,
  output logic converter_clock,
  output logic line_start,
  output logic clamp_enable,
  output logic [11:0] conv_result,
  output logic [3:0] phase
);
  logic [11:0] cyc_reg;
  initial begin
    phase = 4'h0;
    cyc_reg = 12'h000;
    line_start = 1'b0;
    clamp_enable = 1'b0;
  end
  // Converter clock is high in phases 0 to 7; the reference pulse rises at phase 6 for 1ch double, at phase 9 otherwise.
  assign converter_clock = ~phase[3];
  assign reference_sample_clock = (one_ch && !single) ? (phase >= 4'h6 && phase <= 4'h9) :
    (phase >= 4'h9 && phase <= 4'hA);
  assign data_sample_clock = !single && phase >= 4'hC && phase <= 4'hD;
  assign conv_result = cyc_reg;
  // Phase counter; stalling it freezes every pin, which stalls the sample stream.
  always @(posedge pclk) begin
    if (run) begin
      phase <= phase + 4'h1;
      if (phase == 4'hF) begin
        cyc_reg <= cyc_reg + 12'h001;
      end
      if (phase == 4'h3) begin
        line_start <= line_go;
        clamp_enable <= clamp_req;
      end
    end
  end
endmodule : imsmx_timing_gen

// ### testbench/imsmx_seq_tb.sv
// Self-checking bench for the image sampler mux sequencer.
`timescale 1ns/1ps
module imsmx_seq_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic reference_sample_clock, data_sample_clock, converter_clock, line_start, clamp_enable;
  logic run, one_ch, single, line_go, clamp_req;
  logic [11:0] conv_result;
  logic [1:0] mux_select, exp_ch;
  logic reference_hold, data_hold, convert_start, clamp_bias_on, fifo_overrun;
  logic [4:0] gain_code_red, gain_code_green, gain_code_blue;
  logic [7:0] offset_code_red, offset_code_green, offset_code_blue;
  logic [3:0] phase;
  int error_cnt = 0, checked = 0, n_conv = 0, n_ref = 0, n_dat = 0, i, m, k;
  imsmx_seq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reference_sample_clock, .data_sample_clock, .converter_clock, .line_start,
    .clamp_enable, .conv_result, .mux_select, .reference_hold, .data_hold, .convert_start,
    .clamp_bias_on, .gain_code_red, .gain_code_green, .gain_code_blue, .offset_code_red,
    .offset_code_green, .offset_code_blue, .fifo_overrun);
  imsmx_timing_gen gen (.pclk, .run, .one_ch, .single, .line_go, .clamp_req,
    .reference_sample_clock, .data_sample_clock, .converter_clock, .line_start,
    .clamp_enable, .conv_result, .phase);
  // Clock at 200 MHz.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Count the sequencer's pulses as they stand before each edge.
  always @(posedge pclk) begin
    if (convert_start === 1'b1) n_conv++;
    if (reference_hold === 1'b1) n_ref++;
    if (data_hold === 1'b1) n_dat++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, s, x);
    end
  endtask : chk
  // One APB transfer; read data and error are taken where pready stands high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) error_cnt++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Wait for phase 12 of the next n converter cycles.
  task automatic cyc(input int n);
    repeat (n) begin
      do @(negedge pclk); while (phase !== 4'hC);
    end
  endtask : cyc
  // Pop the sample buffer until it reads empty; n counts every read.
  task automatic drain(output int n);
    n = 0;
    do begin
      apb(1'b0, imsmx_pkg::DATA_OFF, 32'h0);
      n++;
    end while (r[16] === 1'b1 && n < 40);
  endtask : drain
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {run, one_ch, single, line_go, clamp_req} = 5'h10;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(r, 32'h0);
    end
    for (i = 1; i < 7; i++) begin
      apb(1'b1, 8'(4 * i), 32'hFFFFFF30 + 32'(i));
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(r, (i < 4) ? 32'h30 + 32'(i) : 32'h10 + 32'(i));
    end
    chk({8'h00, offset_code_red, offset_code_green, offset_code_blue}, 32'h00313233);
    chk({17'h0, gain_code_red, gain_code_green, gain_code_blue}, {17'h0, 15'h52B6});
    apb(1'b0, 8'h24, 32'h0);
    chk({r[30:0], e}, 32'h1);
    $display("test registers done");
    cyc(2);
    n_conv = 0;
    cyc(2);
    chk(32'(n_conv), 32'h0);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, imsmx_pkg::CONFIG_OFF, 32'(k << 6));
      line_go <= 1'b1;
      cyc(2);
      n_conv = 0;
      @(posedge pclk);
      line_go <= 1'b0;
      for (m = 0; m < 4; m++) begin
        cyc(1);
        exp_ch = (m == 1) ? 2'h1 : (((m == 2) == (k == 0)) ? 2'h2 : 2'h0);
        chk({30'h0, mux_select}, {30'h0, exp_ch});
      end
      chk(32'(n_conv), 32'h4);
    end
    $display("test mux order done");
    for (m = 0; m < 4; m++) begin
      apb(1'b1, imsmx_pkg::CONFIG_OFF, 32'(((m & 2) << 2) | (m << 4) | (m & 1)));
      one_ch <= m[1];
      single <= m[0];
      clamp_req <= 1'b1;
      cyc(2);
      n_ref = 0;
      n_dat = 0;
      for (k = 0; k < 3; k++) begin
        cyc(1);
        if (m[1]) chk({30'h0, mux_select}, (m == 3) ? 32'h0 : 32'(m));
      end
      chk(32'(n_ref), 32'h3);
      chk(32'(n_dat), m[0] ? 32'h0 : 32'h3);
      apb(1'b0, imsmx_pkg::STATUS_OFF, 32'h0);
      chk({29'h0, r[7:6], r[4]}, {29'h0, m[1], m[0], !m[0]});
      chk({31'h0, clamp_bias_on}, {31'h0, !m[0]});
    end
    $display("test modes done");
    apb(1'b1, imsmx_pkg::CONFIG_OFF, 32'h0);
    {run, one_ch, single} <= 3'h0;
    repeat (8) @(posedge pclk);
    drain(k);
    chk(32'(k), 32'(imsmx_pkg::FIFO_DEPTH + 1));
    apb(1'b1, imsmx_pkg::STATUS_OFF, 32'h1);
    apb(1'b0, imsmx_pkg::STATUS_OFF, 32'h0);
    chk({29'h0, r[2:0]}, 32'h4);
    run <= 1'b1;
    cyc(20);
    @(posedge pclk);
    run <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({31'h0, fifo_overrun}, 32'h1);
    apb(1'b0, imsmx_pkg::STATUS_OFF, 32'h0);
    chk({29'h0, r[2:0]}, 32'h3);
    drain(k);
    chk(32'(k), 32'(imsmx_pkg::FIFO_DEPTH + 1));
    apb(1'b1, imsmx_pkg::STATUS_OFF, 32'h1);
    apb(1'b0, imsmx_pkg::STATUS_OFF, 32'h0);
    chk({28'h0, fifo_overrun, r[2:0]}, 32'h4);
    $display("test fifo done");
    stop_test();
  end
  // Watchdog: the tests need about 1100 cycles.
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end
endmodule : imsmx_seq_tb
